// File: logic/standard_timer_pkg.sv
// Package for the 16-bit standard timer: register indices, field positions,
// reset values and mode encodings.
// Assumes a byte-wide register port with one-cycle read latency.
package standard_timer_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CONTROL_0    = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_1    = 3'h1;
  localparam logic [2:0] ADDR_COUNT_LOW    = 3'h2;
  localparam logic [2:0] ADDR_COUNT_HIGH   = 3'h3;
  localparam logic [2:0] ADDR_COMPARE_A_LO = 3'h4;
  localparam logic [2:0] ADDR_COMPARE_A_HI = 3'h5;
  localparam logic [2:0] ADDR_PERIOD       = 3'h6;
  localparam logic [2:0] ADDR_FLAGS        = 3'h7;

  // Control 0 fields
  localparam int ON_BIT_POS = 3;

  // Control 1 fields
  localparam int MODE_HI_POS      = 7;
  localparam int MODE_LO_POS      = 6;
  localparam int PIN_FUNC_HI_POS  = 5;
  localparam int PIN_FUNC_LO_POS  = 4;
  localparam int INIT_LEVEL_POS   = 3;
  localparam int POL_INVERT_POS   = 2;
  localparam int DUTY_SWAP_POS    = 1;
  localparam int CLEAR_SELECT_POS = 0;

  // Flag register fields (write one to clear)
  localparam int FLAG_A_POS = 0;
  localparam int FLAG_P_POS = 1;

  // Reset values and counter maximum
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;

  // Mode and pin-function encodings
  localparam logic [1:0] MODE_COMPARE = 2'b00;
  localparam logic [1:0] MODE_CAPTURE = 2'b01;
  localparam logic [1:0] MODE_PWM     = 2'b10;
  localparam logic [1:0] MODE_TIMER   = 2'b11;

  localparam logic [1:0] PIN_NONE   = 2'b00;
  localparam logic [1:0] PIN_LOW    = 2'b01;
  localparam logic [1:0] PIN_HIGH   = 2'b10;
  localparam logic [1:0] PIN_TOGGLE = 2'b11;

  localparam logic [1:0] PWM_INACTIVE = 2'b00;
  localparam logic [1:0] PWM_ACTIVE   = 2'b01;
  localparam logic [1:0] PWM_WAVE     = 2'b10;
  localparam logic [1:0] PWM_SINGLE   = 2'b11;

endpackage

// File: logic/match_unit.sv
// Match detection for the two comparators.
// Assumes counter and compare values are stable within the clock.
module match_unit
(
  // Counter and compare values, run enable
  input  wire logic [15:0] count,
  input  wire logic [15:0] compare_a,
  input  wire logic [7:0]  period_value,
  input  wire logic        running,
  // Match results
  output logic             match_a,
  output logic             match_p,
  output logic             at_max
);

  // Period n ends on count n*256-1; period zero wraps at FFFF
  wire logic [7:0] period_last = period_value - 8'h01;

  // Matches only while the counter runs
  assign match_a = running && (count == compare_a);
  assign match_p = running && (count[15:8] == period_last)
                   && (count[7:0] == 8'hff);
  assign at_max  = running && (count == standard_timer_pkg::COUNT_MAX);

endmodule

// File: logic/pin_shaper.sv
// Output pin shaping: polarity inversion and drive enable.
// Assumes the raw level comes from a register in the timer core.
module pin_shaper
(
  // Raw level and controls
  input  wire logic       raw_level,
  input  wire logic       invert,
  input  wire logic       drive,
  // Pin
  output logic            pin_out,
  output logic            pin_oe
);

  assign pin_out = drive ? (raw_level ^ invert) : 1'b0;
  assign pin_oe  = drive;

endmodule

// File: logic/standard_timer.sv
// 16-bit standard timer with compare A, 8-bit period compare and PWM output.
// Assumes one timer tick per sys_clk and a byte register port whose read
// data stand one cycle after the read strobe.
//
// Notes on behaviour
// - Compare mode: initial level set on on-rise
// - PWM mode: initial-level bit picks active level
// - Single pulse: initial level driven on on-rise
// - Timer mode ignores initial level and invert
// - Invert bit inverts the output pin
// - Swap bit exchanges period and duty roles
// - Clear on A, or on P/overflow
// - Clear-select ignored in PWM, pulse, capture
// - Counter readable as two zero-reset bytes
// - Compare A held in two byte registers
// - Period compares counter high byte, n*256
// - Mode bits select compare, capture, PWM, timer
// - Select 0: both A and P flags raised
// - Select 1: only A flag raised
// - Compare A zero: overflow, no A flag
// - Compare mode pin changes on A only
// - A match sets, clears or toggles pin
// - Timer mode leaves the pin undriven
// - PWM: one register clears, other sets duty
// - PWM: separate A and P flags raised
// - PWM pin-function enables wave or forces level
// - Compare pin codes: none, low, high, toggle
// - PWM pin codes: inactive, active, wave, single pulse
// - On-rise clears counter, on-fall holds count
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
module standard_timer
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Output pin
  output logic            timer_output_pin,
  output logic            timer_output_oe,
  // Match events
  output logic            match_a_flag,
  output logic            match_p_flag
);

  logic        on_bit_q;
  logic        on_prev_q;
  logic [7:0]  control_1_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [7:0]  compare_a_low_q;
  logic [7:0]  compare_a_high_q;
  logic [7:0]  period_compare_q;
  logic [7:0]  count_buf_q;
  logic        flag_a_q;
  logic        flag_p_q;
  logic        level_q;
  logic        level_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;

  // Decoded control fields
  wire logic [1:0] mode_bits = {control_1_q[standard_timer_pkg::MODE_HI_POS],
                                control_1_q[standard_timer_pkg::MODE_LO_POS]};
  wire logic [1:0] pin_function_bits =
    {control_1_q[standard_timer_pkg::PIN_FUNC_HI_POS],
     control_1_q[standard_timer_pkg::PIN_FUNC_LO_POS]};
  wire logic initial_level_bit =
    control_1_q[standard_timer_pkg::INIT_LEVEL_POS];
  wire logic polarity_invert_bit =
    control_1_q[standard_timer_pkg::POL_INVERT_POS];
  wire logic duty_period_swap_bit =
    control_1_q[standard_timer_pkg::DUTY_SWAP_POS];
  wire logic clear_select_bit =
    control_1_q[standard_timer_pkg::CLEAR_SELECT_POS];

  wire logic [15:0] compare_a_value = {compare_a_high_q, compare_a_low_q};

  wire logic is_compare = (mode_bits == standard_timer_pkg::MODE_COMPARE);
  wire logic is_timer   = (mode_bits == standard_timer_pkg::MODE_TIMER);
  wire logic is_pwm_grp = (mode_bits == standard_timer_pkg::MODE_PWM);
  wire logic is_single  = is_pwm_grp &&
                          (pin_function_bits == standard_timer_pkg::PWM_SINGLE);
  wire logic is_pwm     = is_pwm_grp && !is_single;
  wire logic is_capture = (mode_bits == standard_timer_pkg::MODE_CAPTURE);

  wire logic on_rise = on_bit_q && !on_prev_q;

  // Matches start once the count has been cleared, the cycle after on-rise
  wire logic counting = on_bit_q && on_prev_q;

  // Comparators
  logic match_a;
  logic match_p;
  logic at_max;

  match_unit u_match
  (
    .count        (count_q),
    .compare_a    (compare_a_value),
    .period_value (period_compare_q),
    .running      (counting),
    .match_a      (match_a),
    .match_p      (match_p),
    .at_max       (at_max)
  );

  // Compare A of zero never matches; the counter just overflows
  wire logic a_zero    = (compare_a_value == standard_timer_pkg::COUNT_RESET);
  wire logic a_event   = match_a && !a_zero;
  wire logic cmp_like  = is_compare || is_timer;

  // Period match at period zero is the natural overflow
  wire logic p_event   = match_p;

  // Counter clear source
  wire logic clear_by_a   = cmp_like && clear_select_bit && a_event;
  wire logic clear_by_p   = cmp_like && !clear_select_bit && p_event;
  wire logic pwm_period_a = is_pwm && duty_period_swap_bit;
  wire logic clear_pwm    = is_pwm &&
                            (pwm_period_a ? a_event : p_event);
  wire logic clear_cap    = is_capture && p_event;
  wire logic wrap_clear   = clear_by_a || clear_by_p || clear_pwm ||
                            clear_cap || at_max;

  // Flag raise conditions
  wire logic raise_a = a_event;
  wire logic raise_p = p_event &&
                       !(cmp_like && clear_select_bit);

  // PWM duty compare: duty from whichever register does not set period
  wire logic [15:0] duty_ref = pwm_period_a ?
                               {period_compare_q, 8'h00} : compare_a_value;
  wire logic duty_zero_p    = pwm_period_a &&
                              (period_compare_q == 8'h00);
  wire logic duty_active    = duty_zero_p ? 1'b1 : (count_q < duty_ref);

  // Register write strobes and the count-high read strobe
  wire logic wr_ctrl0  = reg_write &&
                         (reg_addr == standard_timer_pkg::ADDR_CONTROL_0);
  wire logic wr_ctrl1  = reg_write &&
                         (reg_addr == standard_timer_pkg::ADDR_CONTROL_1);
  wire logic wr_a_low  = reg_write &&
                         (reg_addr == standard_timer_pkg::ADDR_COMPARE_A_LO);
  wire logic wr_a_high = reg_write &&
                         (reg_addr == standard_timer_pkg::ADDR_COMPARE_A_HI);
  wire logic wr_period = reg_write &&
                         (reg_addr == standard_timer_pkg::ADDR_PERIOD);
  wire logic wr_flags  = reg_write &&
                         (reg_addr == standard_timer_pkg::ADDR_FLAGS);
  wire logic rd_high   = reg_read &&
                         (reg_addr == standard_timer_pkg::ADDR_COUNT_HIGH);

  // Single pulse ends on an A match by dropping the on bit
  wire logic pulse_end = is_single && a_event;

  // Plain increment; wrap at FFFF is handled as a clear
  wire logic [15:0] count_inc = 16'(count_q + 16'h0001);

  // Counter next value
  always_comb
  begin
    if (on_rise)
      count_d = standard_timer_pkg::COUNT_RESET;
    else if (!on_bit_q || pulse_end)
      count_d = count_q;
    else if (wrap_clear && !is_single)
      count_d = standard_timer_pkg::COUNT_RESET;
    else
      count_d = count_inc;
  end

  // Output level next value
  always_comb
  begin
    level_d = level_q;
    if (on_rise)
      level_d = initial_level_bit;
    else if (is_compare && a_event)
    begin
      case (pin_function_bits)
        standard_timer_pkg::PIN_LOW:    level_d = 1'b0;
        standard_timer_pkg::PIN_HIGH:   level_d = 1'b1;
        standard_timer_pkg::PIN_TOGGLE: level_d = !level_q;
        default:                        level_d = level_q;
      endcase
    end
    else if (is_single)
      level_d = (on_bit_q && !pulse_end) ? initial_level_bit
                                         : !initial_level_bit;
    else if (is_pwm)
    begin
      case (pin_function_bits)
        standard_timer_pkg::PWM_INACTIVE: level_d = !initial_level_bit;
        standard_timer_pkg::PWM_ACTIVE:   level_d = initial_level_bit;
        default:
          level_d = (on_bit_q && duty_active) ? initial_level_bit
                                              : !initial_level_bit;
      endcase
    end
  end

  // Read data mux
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_addr == standard_timer_pkg::ADDR_CONTROL_0)
      rdata_d[standard_timer_pkg::ON_BIT_POS] = on_bit_q;
    else if (reg_addr == standard_timer_pkg::ADDR_CONTROL_1)
      rdata_d = control_1_q;
    else if (reg_addr == standard_timer_pkg::ADDR_COUNT_LOW)
      rdata_d = count_buf_q;
    else if (reg_addr == standard_timer_pkg::ADDR_COUNT_HIGH)
      rdata_d = count_q[15:8];
    else if (reg_addr == standard_timer_pkg::ADDR_COMPARE_A_LO)
      rdata_d = compare_a_low_q;
    else if (reg_addr == standard_timer_pkg::ADDR_COMPARE_A_HI)
      rdata_d = compare_a_high_q;
    else if (reg_addr == standard_timer_pkg::ADDR_PERIOD)
      rdata_d = period_compare_q;
    else
    begin
      rdata_d[standard_timer_pkg::FLAG_A_POS] = flag_a_q;
      rdata_d[standard_timer_pkg::FLAG_P_POS] = flag_p_q;
    end
    if (!reg_read)
      rdata_d = 8'h00;
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_bit_q    <= 1'b0;
      on_prev_q   <= 1'b0;
      control_1_q <= standard_timer_pkg::CONTROL_RESET;
    end
    else
    begin
      on_prev_q <= on_bit_q;
      if (wr_ctrl0)
        on_bit_q <= reg_wdata[standard_timer_pkg::ON_BIT_POS];
      else if (pulse_end)
        on_bit_q <= 1'b0;
      if (wr_ctrl1)
        control_1_q <= reg_wdata;
    end
  end

  // Compare registers, written directly byte by byte
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compare_a_low_q  <= standard_timer_pkg::BYTE_RESET;
      compare_a_high_q <= standard_timer_pkg::BYTE_RESET;
      period_compare_q <= standard_timer_pkg::BYTE_RESET;
    end
    else
    begin
      if (wr_a_low)
        compare_a_low_q <= reg_wdata;
      if (wr_a_high)
        compare_a_high_q <= reg_wdata;
      if (wr_period)
        period_compare_q <= reg_wdata;
    end
  end

  // Counter and low-byte read buffer latched on a high-byte read
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q     <= standard_timer_pkg::COUNT_RESET;
      count_buf_q <= standard_timer_pkg::BYTE_RESET;
    end
    else
    begin
      count_q <= count_d;
      if (rd_high)
        count_buf_q <= count_q[7:0];
    end
  end

  // Sticky flags: a set in the clear cycle wins
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end
    else
    begin
      if (raise_a)
        flag_a_q <= 1'b1;
      else if (wr_flags && reg_wdata[standard_timer_pkg::FLAG_A_POS])
        flag_a_q <= 1'b0;
      if (raise_p)
        flag_p_q <= 1'b1;
      else if (wr_flags && reg_wdata[standard_timer_pkg::FLAG_P_POS])
        flag_p_q <= 1'b0;
    end
  end

  // Output level and read data
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      level_q <= level_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign match_a_flag = flag_a_q;
  assign match_p_flag = flag_p_q;

  // Pin driven in output modes only; timer mode ignores level and invert
  wire logic pin_drive = !is_timer && !is_capture;

  pin_shaper u_pin
  (
    .raw_level (level_q),
    .invert    (polarity_invert_bit),
    .drive     (pin_drive),
    .pin_out   (timer_output_pin),
    .pin_oe    (timer_output_oe)
  );

endmodule

// File: test/pin_load.sv
// Load on the timer output pin.
// Assumes a pull-down holds the line low while the pin is undriven.
module pin_load
(
  // Pin
  input  wire logic pin,
  input  wire logic oe,
  // Level at the load
  output logic      level
);
  timeunit 1ns;
  timeprecision 1ps;
  assign level = oe ? pin : 1'b0;
endmodule

// File: test/standard_timer_sva.sv
// Checker for the standard timer top ports.
// Assumes it is bound to standard_timer; mirrors control writes itself.
module standard_timer_sva
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // Pin and flags
  input wire logic       timer_output_pin,
  input wire logic       timer_output_oe,
  input wire logic       match_a_flag,
  input wire logic       match_p_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_q;
  logic       on_q;
  wire  [1:0] mode = ctl_q[7:6];
  wire        lvl  = ctl_q[3] ^ ctl_q[2];
  logic       wr1_q;
  logic       wr2_q;
  wire        quiet = !wr1_q && !wr2_q;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      ctl_q <= 8'h00;
      on_q  <= 1'b0;
      wr1_q <= 1'b0;
      wr2_q <= 1'b0;
    end
    else
    begin
      wr1_q <= reg_write;
      wr2_q <= wr1_q;
      if (reg_write && reg_addr == 3'h1)
        ctl_q <= reg_wdata;
      else if (reg_write && reg_addr == 3'h0)
        on_q <= reg_wdata[3];
    end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_quiet: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00) else $error("stray read data");
  a_timer_undriven: assert property (
    mode == 2'b11 |-> !timer_output_oe) else $error("pin driven in timer");
  a_compare_driven: assert property (
    mode == 2'b00 |-> timer_output_oe) else $error("pin idle in compare");
  a_idle_pin_low: assert property (
    !timer_output_oe |-> !timer_output_pin) else $error("undriven pin high");
  a_start_level: assert property (
    $rose(on_q) && !reg_write && mode == 2'b00 |=> timer_output_pin == lvl)
    else $error("wrong start level");
  a_pin_on_a: assert property (
    mode == 2'b00 && $changed(timer_output_pin) && quiet |-> match_a_flag)
    else $error("pin moved without A match");
  a_no_p_flag: assert property (
    mode == 2'b00 && ctl_q[0] && !match_p_flag |=> !match_p_flag)
    else $error("P flag with A clear");
  a_flag_clear: assert property (
    reg_write && reg_addr == 3'h7 && reg_wdata[1:0] == 2'b11 && !on_q
    |=> !match_a_flag && !match_p_flag) else $error("flags not cleared");
  a_pwm_forced: assert property (
    mode == 2'b10 && !ctl_q[5] && on_q && $past(on_q, 2) && quiet
    |-> timer_output_pin == (lvl ~^ ctl_q[4])) else $error("forced level");
endmodule

// File: test/standard_timer_tb.sv
// Self-checking bench for the standard timer.
// Assumes the checker and the pin load are compiled before it.
module standard_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic       pin;
  logic       oe;
  logic       fa;
  logic       fp;
  logic       seen;
  int         n_fail = 0;
  int         checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  standard_timer standard_timer_i (.sys_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .timer_output_pin(pin), .timer_output_oe(oe),
    .match_a_flag(fa), .match_p_flag(fp));
  pin_load pin_load_i (.pin, .oe, .level(seen));
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic conclude();
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset();
    logic [7:0] d;
    for (int a = 1; a < 8; a++)
    begin
      rd(a[2:0], d);
      chk("register", 16'h0000, {8'h00, d});
    end
    wr(3'h3, 8'h5a);
    wr(3'h4, 8'h12);
    wr(3'h5, 8'h34);
    rd(3'h3, d);
    chk("count_high", 16'h0000, {8'h00, d});
    rd(3'h4, d);
    chk("compare_a_low", 16'h0012, {8'h00, d});
    rd(3'h5, d);
    chk("compare_a_high", 16'h0034, {8'h00, d});
  endtask
  task automatic t_compare();
    logic [1:0] c;
    logic       ini;
    logic       pol;
    logic       e;
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      ini = (c != 2'b10);
      pol = c[0];
      e = (c == 2'b00) ? ini : (c == 2'b01) ? 1'b0 : (c == 2'b10) | !ini;
      wr(3'h0, 8'h00);
      wr(3'h1, {2'b00, c, ini, pol, 2'b01});
      wr(3'h4, 8'h03);
      wr(3'h5, 8'h00);
      wr(3'h7, 8'h03);
      wr(3'h0, 8'h08);
      wait_n(4);
      chk("pin", {15'h0, ini ^ pol}, {15'h0, seen});
      chk("flag_a", 16'h0000, {15'h0, fa});
      wait_n(1);
      chk("pin", {15'h0, e ^ pol}, {15'h0, seen});
      chk("flag_a", 16'h0001, {15'h0, fa});
    end
  endtask
  task automatic t_period();
    logic [7:0] d;
    logic [7:0] h;
    logic [7:0] l;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h80);
    wr(3'h5, 8'h00);
    wr(3'h6, 8'h01);
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h08);
    wait_n(200);
    chk("flags", 16'h0001, {14'h0, fp, fa});
    wait_n(100);
    rd(3'h3, h);
    rd(3'h2, l);
    chk("count", 16'h002c, {h, l});
    rd(3'h7, d);
    chk("flags", 16'h0003, {14'h0, d[1:0]});
  endtask
  task automatic t_hold();
    logic [7:0] h;
    logic [7:0] l;
    wr(3'h0, 8'h00);
    wr(3'h0, 8'h08);
    wr(3'h0, 8'h00);
    rd(3'h3, h);
    rd(3'h2, l);
    chk("count", 16'h0001, {h, l});
    wait_n(20);
    rd(3'h3, h);
    rd(3'h2, l);
    chk("count", 16'h0001, {h, l});
  endtask
  task automatic t_timer();
    wr(3'h1, 8'hcd);
    wr(3'h7, 8'h03);
    wr(3'h4, 8'h03);
    wr(3'h5, 8'h00);
    wr(3'h0, 8'h08);
    wait_n(8);
    chk("oe", 16'h0000, {15'h0, oe});
    chk("pin", 16'h0000, {15'h0, seen});
    chk("flag_a", 16'h0001, {15'h0, fa});
  endtask
  task automatic pwm(input logic [7:0] c1, input logic [15:0] a,
                     input logic [7:0] p, input int win, input int hi_e);
    int hi;
    hi = 0;
    wr(3'h0, 8'h00);
    wr(3'h1, c1);
    wr(3'h4, a[7:0]);
    wr(3'h5, a[15:8]);
    wr(3'h6, p);
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h08);
    wait_n(2);
    for (int i = 0; i < win; i++)
    begin
      wait_n(1);
      hi += seen;
    end
    chk("high_cycles", hi_e[15:0], hi[15:0]);
    if (win > 100)
      chk("flags", 16'h0003, {14'h0, fp, fa});
  endtask
  task automatic t_pwm();
    pwm(8'ha8, 16'h0040, 8'h01, 256, 64);
    pwm(8'ha0, 16'h0040, 8'h01, 256, 192);
    pwm(8'hac, 16'h0040, 8'h01, 256, 192);
    pwm(8'haa, 16'h0300, 8'h01, 769, 256);
    pwm(8'h80, 16'h0040, 8'h01, 10, 10);
    pwm(8'h90, 16'h0040, 8'h01, 10, 0);
  endtask
  task automatic t_single();
    logic [7:0] d;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hb8);
    wr(3'h4, 8'h05);
    wr(3'h5, 8'h00);
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h08);
    wait_n(3);
    chk("pin", 16'h0001, {15'h0, seen});
    wait_n(6);
    chk("pin", 16'h0000, {15'h0, seen});
    rd(3'h0, d);
    chk("on_bit", 16'h0000, {8'h00, d});
  endtask
  initial
  begin
    #100us;
    n_fail++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_compare();
    t_period();
    t_hold();
    t_timer();
    t_pwm();
    t_single();
    conclude();
  end
endmodule
bind standard_timer standard_timer_sva standard_timer_sva_i (.sys_clk,
  .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .timer_output_pin, .timer_output_oe, .match_a_flag, .match_p_flag);
